// ### logic/pin_function_ctrl.sv
// Pin function control for port D pins 9..0 and port E pins 15..0.
// Assumes all inputs are synchronous to clk_in and that reset_in is the
// external power-on reset; watchdog reset, standby and sleep never reach it.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Port D bit: 0 GPIO, 1 data bus
// - ROM disabled: port D always data bus
// - Single-chip: port D always GPIO
// - Port E direction: 16 bits, 1 output
// - Port E direction only for GPIO/timer
// - Port E direction clears on power-on reset
// - Port E direction survives watchdog, standby, sleep
// - Two port E function registers, upper/lower; only the upper one is in this block
// - Port E functions clear on power-on only
// - Single-chip: port E bus/DMA selections ignored
// - Pin 15 field: 00 GPIO, 10 ack1
// - Pin 14: 00 GPIO, 10 ack0, 11 hold
// - Upper function bits 11..0 read zero
// - Port D function clears on power-on only
// - Port D bits act only ROM-enabled extended
// - Port D GPIO direction: 1 output
module pin_function_ctrl (
  // Clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  // Chip operating mode
  input  wire logic [1:0]  mode_in,
  // Register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  // Port D sources
  input  wire logic [9:0]  pd_gpio_data_in,
  input  wire logic [9:0]  bus_data_in,
  input  wire logic        bus_data_oe_in,
  // Port E sources
  input  wire logic [15:0] pe_gpio_data_in,
  input  wire logic        dma_ack_channel1_src_in,
  input  wire logic        dma_ack_channel0_src_in,
  input  wire logic        address_hold_src_in,
  // Port D pins
  output logic      [9:0]  pd_pin_out,
  output logic      [9:0]  pd_pin_oe_out,
  output logic      [9:0]  pd_bus_sel_out,
  // Port E pins
  output logic      [15:0] pe_pin_out,
  output logic      [15:0] pe_pin_oe_out
);

  // ==========================================================
  // Registers
  logic [15:0] port_d_low_function_select_reg;   // Port D function bits
  logic [15:0] port_d_low_function_select_next;
  logic [15:0] port_d_low_direction_reg;         // Port D direction
  logic [15:0] port_d_low_direction_next;
  logic [15:0] port_e_direction_reg;             // Port E direction
  logic [15:0] port_e_direction_next;
  logic [15:0] port_e_upper_function_select_reg; // Port E pins 15..14
  logic [15:0] port_e_upper_function_select_next;
  logic [15:0] rdata_next;
  logic [9:0]  pd_pin_next;
  logic [9:0]  pd_oe_next;
  logic [9:0]  pd_sel_next;
  logic [15:0] pe_pin_next;
  logic [15:0] pe_oe_next;
  logic [1:0]  pe15_code;                        // Pin 15 field
  logic [1:0]  pe14_code;                        // Pin 14 field

  assign pe15_code = port_e_upper_function_select_reg[
    pin_function_pkg::PE15_FIELD_HI:pin_function_pkg::PE15_FIELD_LO];
  assign pe14_code = port_e_upper_function_select_reg[
    pin_function_pkg::PE14_FIELD_HI:pin_function_pkg::PE14_FIELD_LO];

  // ==========================================================
  // Register writes and reads
  // Registers clear only on the power-on reset path; the watchdog reset,
  // standby and sleep are not wired here, so contents survive them.
  always_comb begin
    port_d_low_function_select_next   = port_d_low_function_select_reg;
    port_d_low_direction_next         = port_d_low_direction_reg;
    port_e_direction_next             = port_e_direction_reg;
    port_e_upper_function_select_next = port_e_upper_function_select_reg;
    rdata_next                        = 16'h0000;
    // Write decode
    if (wr_in) begin
      case (addr_in)
        pin_function_pkg::PD_FUNC_OFFSET: begin
          port_d_low_function_select_next = wdata_in;
        end
        pin_function_pkg::PD_DIR_OFFSET: begin
          port_d_low_direction_next = wdata_in;
        end
        pin_function_pkg::PE_DIR_OFFSET: begin
          port_e_direction_next = wdata_in;
        end
        pin_function_pkg::PE_FUNC_OFFSET: begin
          // Reserved bits never store, so they read back zero
          port_e_upper_function_select_next =
            wdata_in & pin_function_pkg::PE_FUNC_WRITABLE;
        end
        default: begin
          // Unmapped write is dropped
        end
      endcase
    end
    // Read decode; unmapped reads return zero
    if (rd_in) begin
      case (addr_in)
        pin_function_pkg::PD_FUNC_OFFSET: begin
          rdata_next = port_d_low_function_select_reg;
        end
        pin_function_pkg::PD_DIR_OFFSET: begin
          rdata_next = port_d_low_direction_reg;
        end
        pin_function_pkg::PE_DIR_OFFSET: begin
          rdata_next = port_e_direction_reg;
        end
        pin_function_pkg::PE_FUNC_OFFSET: begin
          rdata_next = port_e_upper_function_select_reg;
        end
        default: begin
          rdata_next = 16'h0000;
        end
      endcase
    end
  end

  // ==========================================================
  // Port D routing
  // Pins 9..0 only; the upper port D pins live in another block.
  always_comb begin
    pd_pin_next = pd_gpio_data_in;
    pd_oe_next  = port_d_low_direction_reg[9:0];
    pd_sel_next = 10'h000;
    case (mode_in)
      pin_function_pkg::MODE_ROM_OFF_8,
      pin_function_pkg::MODE_ROM_OFF_16: begin
        // Function bits ignored: every pin is data bus
        pd_sel_next = 10'h3ff;
      end
      pin_function_pkg::MODE_ROM_ON: begin
        pd_sel_next = port_d_low_function_select_reg[9:0];
      end
      pin_function_pkg::MODE_SINGLE: begin
        pd_sel_next = 10'h000;
      end
      default: begin
        pd_sel_next = 10'h000;
      end
    endcase
    // Bus lines take data and direction from the bus controller
    for (int i = 0; i < pin_function_pkg::PD_PINS; i++) begin
      if (pd_sel_next[i]) begin
        pd_pin_next[i] = bus_data_in[i];
        pd_oe_next[i]  = bus_data_oe_in;
      end
    end
  end

  // ==========================================================
  // Port E routing
  // Lower eight pins are general I/O here: their function register sits
  // outside, and timer pins use the same direction bits anyway.
  always_comb begin
    pe_pin_next = pe_gpio_data_in;
    pe_oe_next  = port_e_direction_reg;
    if (mode_in != pin_function_pkg::MODE_SINGLE) begin
      // Pin 15: only code 10 selects the ack; reserved codes stay GPIO
      if (pe15_code == pin_function_pkg::FUNC_DACK) begin
        pe_pin_next[pin_function_pkg::PE15_PIN] =
          dma_ack_channel1_src_in;
        pe_oe_next[pin_function_pkg::PE15_PIN]  = 1'b1;
      end
      // Pin 14: ack0 or address hold
      case (pe14_code)
        pin_function_pkg::FUNC_DACK: begin
          pe_pin_next[pin_function_pkg::PE14_PIN] =
            dma_ack_channel0_src_in;
          pe_oe_next[pin_function_pkg::PE14_PIN]  = 1'b1;
        end
        pin_function_pkg::FUNC_AH: begin
          pe_pin_next[pin_function_pkg::PE14_PIN] =
            address_hold_src_in;
          pe_oe_next[pin_function_pkg::PE14_PIN]  = 1'b1;
        end
        default: begin
          // General I/O or reserved code
        end
      endcase
    end
    // Single-chip mode leaves both pins on the GPIO path
  end

  // ==========================================================
  // State and output flops
  // Only the power-on reset clears; ce_in low freezes everything.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      port_d_low_function_select_reg   <= pin_function_pkg::REG_RESET;
      port_d_low_direction_reg         <= pin_function_pkg::REG_RESET;
      port_e_direction_reg             <= pin_function_pkg::REG_RESET;
      port_e_upper_function_select_reg <= pin_function_pkg::REG_RESET;
      rdata_out                        <= 16'h0000;
      pd_pin_out                       <= 10'h000;
      pd_pin_oe_out                    <= 10'h000;
      pd_bus_sel_out                   <= 10'h000;
      pe_pin_out                       <= 16'h0000;
      pe_pin_oe_out                    <= 16'h0000;
    end else if (ce_in) begin
      port_d_low_function_select_reg   <= port_d_low_function_select_next;
      port_d_low_direction_reg         <= port_d_low_direction_next;
      port_e_direction_reg             <= port_e_direction_next;
      port_e_upper_function_select_reg <= port_e_upper_function_select_next;
      rdata_out                        <= rdata_next;
      pd_pin_out                       <= pd_pin_next;
      pd_pin_oe_out                    <= pd_oe_next;
      pd_bus_sel_out                   <= pd_sel_next;
      pe_pin_out                       <= pe_pin_next;
      pe_pin_oe_out                    <= pe_oe_next;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_pe_write;
    ce_in && wr_in && addr_in == pin_function_pkg::PE_FUNC_OFFSET;
  endsequence
  sequence s_pe_read;
    ce_in && rd_in && addr_in == pin_function_pkg::PE_FUNC_OFFSET;
  endsequence

  a_pd_rom_off: assert property (ce_in && mode_in[1] == 1'b0
    |=> pd_bus_sel_out == 10'h3ff)
    else $error("port D not bus with ROM off");
  a_pd_single: assert property (ce_in && mode_in == pin_function_pkg::MODE_SINGLE
    |=> pd_bus_sel_out == 10'h000)
    else $error("port D not GPIO in single-chip");
  a_pd_rom_on: assert property (ce_in && mode_in == pin_function_pkg::MODE_ROM_ON
    |=> pd_bus_sel_out == $past(port_d_low_function_select_reg[9:0]))
    else $error("port D select not from register");
  a_pd_gpio_dir: assert property (ce_in && mode_in == pin_function_pkg::MODE_SINGLE
    |=> pd_pin_oe_out == $past(port_d_low_direction_reg[9:0]))
    else $error("port D GPIO direction wrong");
  a_pe_low_dir: assert property (ce_in
    |=> pe_pin_oe_out[7:0] == $past(port_e_direction_reg[7:0]))
    else $error("port E low direction wrong");
  a_pe_single: assert property (ce_in && mode_in == pin_function_pkg::MODE_SINGLE
    |=> pe_pin_oe_out[15:14] == $past(port_e_direction_reg[15:14]))
    else $error("port E function used in single-chip");
  a_pe15_ack: assert property (ce_in && mode_in != pin_function_pkg::MODE_SINGLE
    && pe15_code == pin_function_pkg::FUNC_DACK
    |=> pe_pin_oe_out[15] && pe_pin_out[15] == $past(dma_ack_channel1_src_in))
    else $error("pin 15 ack not routed");
  a_pe14_hold: assert property (ce_in && mode_in != pin_function_pkg::MODE_SINGLE
    && pe14_code == pin_function_pkg::FUNC_AH
    |=> pe_pin_oe_out[14] && pe_pin_out[14] == $past(address_hold_src_in))
    else $error("pin 14 hold not routed");
  // A write strobe, one idle edge, then a read of the same register
  a_pe_reserved_zero: assert property (s_pe_write ##2 s_pe_read
    |=> rdata_out[11:0] == 12'h000)
    else $error("reserved bits read nonzero");
  a_pe_dir_hold: assert property (!(ce_in && wr_in
    && addr_in == pin_function_pkg::PE_DIR_OFFSET)
    |=> $stable(port_e_direction_reg))
    else $error("port E direction changed without write");

endmodule : pin_function_ctrl

`default_nettype wire

// ### logic/pin_function_pkg.sv
// Constants for the port D / port E pin function block.
// Assumes a 16-bit register port and a two-bit chip mode input.
package pin_function_pkg;
  // ==========================================================
  // Register offsets (byte addresses, one halfword each)
  localparam logic [3:0] PD_FUNC_OFFSET = 4'h0;
  localparam logic [3:0] PD_DIR_OFFSET  = 4'h2;
  localparam logic [3:0] PE_DIR_OFFSET  = 4'h4;
  localparam logic [3:0] PE_FUNC_OFFSET = 4'h6;
  // ==========================================================
  // Widths and reset values
  localparam int REG_WIDTH = 16;
  localparam int PD_PINS   = 10;
  localparam int PE_PINS   = 16;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // ==========================================================
  // Upper port E function fields
  localparam int PE15_FIELD_HI = 15;
  localparam int PE15_FIELD_LO = 14;
  localparam int PE14_FIELD_HI = 13;
  localparam int PE14_FIELD_LO = 12;
  localparam logic [15:0] PE_FUNC_WRITABLE = 16'hf000;
  localparam int PE15_PIN = 15;
  localparam int PE14_PIN = 14;
  // Field codes
  localparam logic [1:0] FUNC_GPIO = 2'h0;
  localparam logic [1:0] FUNC_DACK = 2'h2;
  localparam logic [1:0] FUNC_AH   = 2'h3;
  // ==========================================================
  // Chip operating mode codes
  localparam logic [1:0] MODE_ROM_OFF_8  = 2'h0;
  localparam logic [1:0] MODE_ROM_OFF_16 = 2'h1;
  localparam logic [1:0] MODE_ROM_ON     = 2'h2;
  localparam logic [1:0] MODE_SINGLE     = 2'h3;
endpackage : pin_function_pkg

// ### test/pin_peer_model.sv
// Outside device on the port E pins: sees what the block drives.
// Assumes pin value and enable come straight from the pin block.
`timescale 1ns/1ps
`default_nettype none
module pin_peer_model (
  // Clock
  input  wire logic        clk_in,
  // Pins from the block
  input  wire logic [15:0] pin_in,
  input  wire logic [15:0] oe_in,
  // Level seen outside
  output logic      [15:0] level_out
);
  logic [15:0] last_reg = 16'h0000; // Level seen at the last edge
  // ==========================================================
  // Level resolve
  // A released pin shows the inverse of its last level, so a stale
  // value can never pass for a driven one
  always_comb begin
    level_out = (pin_in & oe_in) | (~last_reg & ~oe_in);
  end
  always_ff @(posedge clk_in) begin
    last_reg <= level_out;
  end
endmodule : pin_peer_model
`default_nettype wire

// ### test/pin_function_ctrl_tb.sv
// Testbench for the pin function block: register port and pin routing.
// Assumes the block answers reads one cycle later and pins one cycle late.
`timescale 1ns/1ps
`default_nettype none
module pin_function_ctrl_tb;
  logic        clk_in, reset_in, ce_in, wr_in, rd_in, bus_data_oe_in;
  logic        ack1_src, ack0_src, hold_src;
  logic [1:0]  mode_in;
  logic [3:0]  addr_in;
  logic [15:0] wdata_in, rdata_out, pe_gpio_data_in, pe_pin_out, pe_pin_oe_out, level;
  logic [9:0]  pd_gpio_data_in, bus_data_in, pd_pin_out, pd_pin_oe_out, pd_bus_sel_out;
  logic [15:0] pdf, pdd, ped, pef; // Shadow copies of what was written
  int          n_mismatch, n_checks;
  // ==========================================================
  // Design and outside peer
  pin_function_ctrl i_dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .mode_in(mode_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .pd_gpio_data_in(pd_gpio_data_in),
    .bus_data_in(bus_data_in), .bus_data_oe_in(bus_data_oe_in),
    .pe_gpio_data_in(pe_gpio_data_in), .dma_ack_channel1_src_in(ack1_src),
    .dma_ack_channel0_src_in(ack0_src), .address_hold_src_in(hold_src),
    .pd_pin_out(pd_pin_out), .pd_pin_oe_out(pd_pin_oe_out),
    .pd_bus_sel_out(pd_bus_sel_out), .pe_pin_out(pe_pin_out),
    .pe_pin_oe_out(pe_pin_oe_out));
  pin_peer_model i_peer (.clk_in(clk_in), .pin_in(pe_pin_out), .oe_in(pe_pin_oe_out),
    .level_out(level));
  // ==========================================================
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in    <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in   <= 1'b0;
    @(negedge clk_in);
    chk("rdata", rdata_out, exp);
  endtask : rchk
  // Expected pins worked out from the shadows and the mode
  task automatic pins();
    logic [9:0]  bsel;
    logic [15:0] pe, oe;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    bsel = (mode_in == pin_function_pkg::MODE_SINGLE) ? 10'h000 :
           (mode_in == pin_function_pkg::MODE_ROM_ON) ? pdf[9:0] : 10'h3ff;
    pe = pe_gpio_data_in;
    oe = ped;
    if (mode_in != pin_function_pkg::MODE_SINGLE) begin
      if (pef[15:14] == pin_function_pkg::FUNC_DACK) begin
        pe[15] = ack1_src;
        oe[15] = 1'b1;
      end
      if (pef[13:12] == pin_function_pkg::FUNC_DACK) begin
        pe[14] = ack0_src;
        oe[14] = 1'b1;
      end
      if (pef[13:12] == pin_function_pkg::FUNC_AH) begin
        pe[14] = hold_src;
        oe[14] = 1'b1;
      end
    end
    chk("pd_bus_sel", {6'h00, pd_bus_sel_out}, {6'h00, bsel});
    chk("pd_pin", {6'h00, pd_pin_out},
        {6'h00, (bus_data_in & bsel) | (pd_gpio_data_in & ~bsel)});
    chk("pd_oe", {6'h00, pd_pin_oe_out},
        {6'h00, ({10{bus_data_oe_in}} & bsel) | (pdd[9:0] & ~bsel)});
    chk("pe_pin", pe_pin_out, pe);
    chk("pe_oe", pe_pin_oe_out, oe);
    chk("pe_level", level & oe, pe & oe);
  endtask : pins
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Main sequence
  initial begin
    logic [3:0] offs [4];
    offs = '{pin_function_pkg::PD_FUNC_OFFSET, pin_function_pkg::PD_DIR_OFFSET,
             pin_function_pkg::PE_DIR_OFFSET, pin_function_pkg::PE_FUNC_OFFSET};
    n_mismatch = 0;
    n_checks = 0;
    ce_in = 1'b1;
    {reset_in, wr_in, rd_in, addr_in, wdata_in} = {1'b1, 22'h000000};
    mode_in = pin_function_pkg::MODE_ROM_ON;
    {pd_gpio_data_in, bus_data_in, bus_data_oe_in} = {10'h2b5, 10'h14a, 1'b1};
    {pe_gpio_data_in, ack1_src, ack0_src, hold_src} = {16'h5c5a, 3'h5};
    {pdf, pdd, ped, pef} = 64'h0;
    for (int pass = 0; pass < 2; pass++) begin
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b0;
      // Power-on reset clears every register, also after a mid-run reset
      for (int i = 0; i < 4; i++) begin
        rchk(offs[i], 16'h0000);
      end
      rchk(4'h8, 16'h0000);
      pins();
      // Software keeps the reserved upper function bits at zero
      {pdf, pdd, ped, pef} = {16'hfd2d, 16'h0396, 16'h3fa5, 16'hf000};
      wr(pin_function_pkg::PD_FUNC_OFFSET, pdf);
      wr(pin_function_pkg::PD_DIR_OFFSET, pdd);
      wr(pin_function_pkg::PE_DIR_OFFSET, ped);
      wr(pin_function_pkg::PE_FUNC_OFFSET, pef);
      rchk(pin_function_pkg::PE_FUNC_OFFSET, 16'hf000);
      rchk(pin_function_pkg::PE_DIR_OFFSET, ped);
      rchk(pin_function_pkg::PD_FUNC_OFFSET, pdf);
      // Unmapped write must clobber nothing; later reads and pins show it
      wr(4'h8, 16'hffff);
      // A write while the clock enable is low must not land
      @(posedge clk_in);
      ce_in <= 1'b0;
      wr(pin_function_pkg::PE_DIR_OFFSET, ~ped);
      ce_in <= 1'b1;
      rchk(pin_function_pkg::PE_DIR_OFFSET, ped);
      // Every mode against every pin 15 and pin 14 code
      for (int m = 0; m < 4; m++) begin
        for (int c = 0; c < 16; c++) begin
          pef = {c[3:0], 12'h000};
          wr(pin_function_pkg::PE_FUNC_OFFSET, pef);
          mode_in <= m[1:0];
          pins();
        end
      end
      rchk(pin_function_pkg::PD_DIR_OFFSET, pdd);
      // Mid-run power-on reset, launched on a rising edge; the second
      // pass flips the bus enable and the function sources
      @(posedge clk_in);
      reset_in <= 1'b1;
      mode_in  <= pin_function_pkg::MODE_ROM_ON;
      bus_data_oe_in <= 1'b0;
      {ack1_src, ack0_src, hold_src} <= 3'h2;
      {pdf, pdd, ped, pef} = 64'h0;
    end
    report_and_stop();
  end
endmodule : pin_function_ctrl_tb
`default_nettype wire
